// ---- logic/ctmm_defines.svh ----
`ifndef CTMM_DEFINES_SVH
`define CTMM_DEFINES_SVH

// Operating mode codes (mode_select_high, mode_select_low)
`define CTMM_MODE_CMP 2'h0
`define CTMM_MODE_PWM 2'h2
`define CTMM_MODE_TMR 2'h3

// Output action codes in compare-match output mode
`define CTMM_ACT_NONE 2'h0
`define CTMM_ACT_LOW 2'h1
`define CTMM_ACT_HIGH 2'h2
`define CTMM_ACT_TOGGLE 2'h3

// Output action codes in PWM mode
`define CTMM_PWM_INACTIVE 2'h0
`define CTMM_PWM_ACTIVE 2'h1
`define CTMM_PWM_WAVE 2'h2

// Full-scale counts, one beyond the largest counter value
`define CTMM_FULL_TEN 17'h00400
`define CTMM_FULL_SIXTEEN 17'h10000

// Counter masks per instance width
`define CTMM_MASK_TEN 16'h03FF
`define CTMM_MASK_SIXTEEN 16'hFFFF

// Low padding that scales the coarse period value (128 or 256 clocks)
`define CTMM_RP_PAD_TEN 7'h00
`define CTMM_RP_PAD_SIXTEEN 8'h00
`define CTMM_RP_HEAD_TEN 7'h00
`define CTMM_RP_HEAD_SIXTEEN 1'h0

// Coarse period codes that mean a full-scale period
`define CTMM_RP_ZERO_TEN 3'h0
`define CTMM_RP_ZERO_SIXTEEN 8'h00

// Counter reset value and increment
`define CTMM_CNT_RST 16'h0000
`define CTMM_CNT_ONE 17'h00001
`define CTMM_CMP_ZERO 16'h0000

`endif

// ---- logic/ctmm_period_calc.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ctmm_defines.svh"
module ctmm_period_calc
  import ctmm_pkg::*;
(
  input wire logic wide,
  input wire logic swap,
  input wire ctmm_cnt_t a_value,
  input wire logic [7:0] p_value,
  output ctmm_span_t full_scale,
  output ctmm_span_t a_span,
  output ctmm_span_t p_span,
  output ctmm_span_t pwm_period,
  output ctmm_span_t pwm_duty
);

  logic a_zero; // Compare A value of zero

  // Scale the coarse period value; a zero code means a full-scale count
  always_comb
  begin
    if (wide)
    begin
      full_scale = `CTMM_FULL_SIXTEEN;
      a_span = {1'b0, a_value & `CTMM_MASK_SIXTEEN};
      if (p_value == `CTMM_RP_ZERO_SIXTEEN)
      begin
        p_span = `CTMM_FULL_SIXTEEN;
      end
      else
      begin
        p_span = {`CTMM_RP_HEAD_SIXTEEN, p_value, `CTMM_RP_PAD_SIXTEEN};
      end
    end
    else
    begin
      full_scale = `CTMM_FULL_TEN;
      a_span = {1'b0, a_value & `CTMM_MASK_TEN};
      if (p_value[2:0] == `CTMM_RP_ZERO_TEN)
      begin
        p_span = `CTMM_FULL_TEN;
      end
      else
      begin
        p_span = {`CTMM_RP_HEAD_TEN, p_value[2:0], `CTMM_RP_PAD_TEN};
      end
    end
  end

  assign a_zero = (a_span[15:0] == `CTMM_CMP_ZERO);

  // Assign period and duty roles; a zero A period has no meaning, so run full scale
  always_comb
  begin
    if (swap)
    begin
      pwm_period = a_zero ? full_scale : a_span;
      pwm_duty = p_span;
    end
    else
    begin
      pwm_period = p_span;
      pwm_duty = a_span;
    end
  end

endmodule
`default_nettype wire

// ---- logic/ctmm_pkg.sv ----
`default_nettype none
package ctmm_pkg;

  // Run state of the counter, one-hot
  typedef enum logic [1:0]
  {
    CTMM_ST_OFF = 2'b01,
    CTMM_ST_RUN = 2'b10
  } ctmm_state_e;

  // Control bits of the timer, as software writes them
  typedef struct packed
  {
    logic mode_select_high;
    logic mode_select_low;
    logic output_action_high;
    logic output_action_low;
    logic output_initial_level;
    logic output_invert;
    logic period_duty_swap;
    logic clear_on_a_select;
  } ctmm_cfg_s;

  // Counter width and comparison span
  typedef logic [15:0] ctmm_cnt_t;
  typedef logic [16:0] ctmm_span_t;

endpackage
`default_nettype wire

// ---- logic/ctmm_sticky_flag.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctmm_sticky_flag
  import ctmm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag
);

  // Flag holds until software clears it; a set in the clear cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flag <= 1'b0;
    end
    else if (ce)
    begin
      if (set_pulse)
      begin
        flag <= 1'b1;
      end
      else if (clr_pulse)
      begin
        flag <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/ctmm_timer.sv ----
// Contract
// - Mode code 00 selects compare-match output
// - Clear-on-A low: P match clears, zero rolls
// - Clear-on-A low: both A and P flags set
// - Clear-on-A high: A match clears, no P flag
// - Zero A value: overflow at full scale, no flag
// - Compare mode: only A matches change the pin
// - Action 00: pin unchanged on A match
// - Action 01 low, 10 high, 11 toggle
// - Counter-on rising edge loads initial pin level
// - Mode 11: like compare mode, pin not driven
// - Mode 10: PWM, one period, one duty compare
// - PWM ignores clear-on-A select bit
// - Swap bit picks period and duty registers
// - Swap 0: P period, A duty; 1 reversed
// - PWM sets A and P flags on matches
// - PWM polarity, action enable and invert apply
// - PWM action 00 inactive, 01 active, 10 wave
// - Ten-bit period code in 128-clock steps, 000 is 1024
// - Duty at or beyond period gives full active
// - Swap set: period from A, duty from P
// - Sixteen-bit period is value times 256, zero 65536
// - Sixteen-bit swapped duty is value times 256, zero 65536
// - PWM counting and flags continue while forced
`timescale 1ns/10ps
`default_nettype none
`include "ctmm_defines.svh"
module ctmm_timer
  import ctmm_pkg::*;
#(
  parameter logic WIDE = 1'b0
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire ctmm_cfg_s CFG,
  input wire logic COUNTER_ON,
  input wire ctmm_cnt_t COMPARE_A_VALUE,
  input wire logic [7:0] PERIOD_COMPARE_VALUE,
  input wire logic MATCH_A_FLAG_CLR,
  input wire logic MATCH_P_FLAG_CLR,
  output logic MATCH_A_FLAG,
  output logic MATCH_P_FLAG,
  output ctmm_cnt_t COUNT,
  output logic TIMER_OUT,
  output logic TIMER_OUT_EN
);

  // Decoded control fields
  logic [1:0] mode; // Operating mode code
  logic [1:0] action; // Output action code
  logic mode_cmp; // Compare-match output mode
  logic mode_pwm; // PWM output mode
  logic mode_tmr; // Plain timer/counter mode
  logic mode_known; // Any defined mode

  // Run state and edge detection of the counter-on bit
  ctmm_state_e state_reg; // Present run state
  ctmm_state_e state_next; // Next run state
  logic on_rise; // Counter-on went from low to high
  logic tick; // Counter advances this cycle

  // Counter and comparison spans
  ctmm_cnt_t cnt_reg; // Internal count-up counter
  ctmm_cnt_t cnt_next; // Its next value
  ctmm_span_t inc; // Counter plus one, one bit wider
  ctmm_span_t full_scale; // Count at which the counter overflows
  ctmm_span_t a_span; // Compare A value, masked to width
  ctmm_span_t p_span; // Coarse period value, scaled
  ctmm_span_t pwm_period; // PWM period in timer clocks
  ctmm_span_t pwm_duty; // PWM active time in timer clocks

  // Match and clear events
  logic hit_a; // Counter reaches a non-zero compare A value
  logic hit_p; // Counter reaches the scaled period value
  logic wrap; // Counter reaches full scale
  logic clear_now; // Counter returns to zero
  logic set_a; // Match-A flag set event
  logic set_p; // Match-P flag set event
  logic [1:0] flag_set; // Flag set events, A in bit 0
  logic [1:0] flag_clr; // Flag clear requests, A in bit 0
  logic [1:0] flag_val; // Flag values, A in bit 0

  // Output pin path
  logic cmp_pin_reg; // Pin level in compare-match output mode
  logic cmp_pin_next; // Its next value
  logic pwm_active; // Waveform in its active phase
  logic pwm_level; // PWM level before inversion
  logic out_next; // Pin level after inversion
  logic out_reg; // Registered pin level
  logic out_en_reg; // Registered pin enable

  assign mode = {CFG.mode_select_high, CFG.mode_select_low};
  assign action = {CFG.output_action_high, CFG.output_action_low};
  assign mode_cmp = (mode == `CTMM_MODE_CMP);
  assign mode_pwm = (mode == `CTMM_MODE_PWM);
  assign mode_tmr = (mode == `CTMM_MODE_TMR);
  // Code 01 is undefined here, so the counter simply holds
  assign mode_known = mode_cmp | mode_pwm | mode_tmr;

  // Scale compare values and pick period and duty roles
  ctmm_period_calc u_period_calc
  (
    .wide (WIDE),
    .swap (CFG.period_duty_swap),
    .a_value (COMPARE_A_VALUE),
    .p_value (PERIOD_COMPARE_VALUE),
    .full_scale (full_scale),
    .a_span (a_span),
    .p_span (p_span),
    .pwm_period (pwm_period),
    .pwm_duty (pwm_duty)
  );

  // Next run state follows the counter-on bit
  always_comb
  begin
    state_next = state_reg;
    on_rise = 1'b0;
    unique case (state_reg)
      CTMM_ST_OFF:
      begin
        // The rising edge is seen here, from the off state only
        if (COUNTER_ON)
        begin
          state_next = CTMM_ST_RUN;
          on_rise = 1'b1;
        end
      end
      CTMM_ST_RUN:
      begin
        // Turning off keeps the residual count
        if (!COUNTER_ON)
        begin
          state_next = CTMM_ST_OFF;
        end
      end
      default:
      begin
        state_next = CTMM_ST_OFF;
      end
    endcase
  end

  // Run state register
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= CTMM_ST_OFF;
    end
    else if (CE)
    begin
      state_reg <= state_next;
    end
  end

  // The edge cycle itself only zeroes the counter, counting starts after it
  assign tick = (state_reg == CTMM_ST_RUN) & COUNTER_ON & mode_known;

  // Comparisons look at the value the counter is about to reach
  assign inc = {1'b0, cnt_reg} + `CTMM_CNT_ONE;
  assign wrap = (inc == full_scale);
  assign hit_a = (inc == a_span) && (a_span[15:0] != `CTMM_CMP_ZERO);
  assign hit_p = (inc == p_span);

  // Clear source depends on the mode and the clear-on-A select bit
  always_comb
  begin
    if (mode_pwm)
    begin
      // Only the period register clears; clear-on-A is not looked at
      clear_now = (inc == pwm_period) | wrap;
    end
    else if (CFG.clear_on_a_select)
    begin
      // A zero A value never hits, so the counter runs to full scale
      clear_now = hit_a | wrap;
    end
    else
    begin
      // A zero period code scales to full scale, which is a plain rollover
      clear_now = hit_p | wrap;
    end
  end

  // Flag events per mode
  always_comb
  begin
    set_a = 1'b0;
    set_p = 1'b0;
    if (tick)
    begin
      if (mode_pwm)
      begin
        // Flags keep coming even while the pin is forced
        set_a = hit_a;
        set_p = hit_p;
      end
      else if (CFG.clear_on_a_select)
      begin
        set_a = hit_a;
        set_p = 1'b0;
      end
      else
      begin
        set_a = hit_a;
        set_p = hit_p;
      end
    end
  end

  // Next counter value
  always_comb
  begin
    cnt_next = cnt_reg;
    if (on_rise)
    begin
      cnt_next = `CTMM_CNT_RST;
    end
    else if (tick)
    begin
      if (clear_now)
      begin
        cnt_next = `CTMM_CNT_RST;
      end
      else
      begin
        cnt_next = inc[15:0];
      end
    end
  end

  // Counter register
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      cnt_reg <= `CTMM_CNT_RST;
    end
    else if (CE)
    begin
      cnt_reg <= cnt_next;
    end
  end

  // Sticky match flags, A then P
  assign flag_set = {set_p, set_a};
  assign flag_clr = {MATCH_P_FLAG_CLR, MATCH_A_FLAG_CLR};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_flag
      ctmm_sticky_flag u_flag
      (
        .clk (REF_CLK),
        .rst_n (RST_N),
        .ce (CE),
        .set_pulse (flag_set[gi]),
        .clr_pulse (flag_clr[gi]),
        .flag (flag_val[gi])
      );
    end
  endgenerate

  // Compare-mode pin level: loaded on the rising edge, changed by A matches
  always_comb
  begin
    cmp_pin_next = cmp_pin_reg;
    if (on_rise)
    begin
      cmp_pin_next = CFG.output_initial_level;
    end
    else if (mode_cmp && set_a)
    begin
      // P matches never reach this path
      unique case (action)
        `CTMM_ACT_NONE:
        begin
          cmp_pin_next = cmp_pin_reg;
        end
        `CTMM_ACT_LOW:
        begin
          cmp_pin_next = 1'b0;
        end
        `CTMM_ACT_HIGH:
        begin
          cmp_pin_next = 1'b1;
        end
        `CTMM_ACT_TOGGLE:
        begin
          cmp_pin_next = ~cmp_pin_reg;
        end
      endcase
    end
  end

  // Compare-mode pin register
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      cmp_pin_reg <= 1'b0;
    end
    else if (CE)
    begin
      cmp_pin_reg <= cmp_pin_next;
    end
  end

  // Edge-aligned waveform: active from the clear until the duty count
  // A duty at or past the period never ends the active phase
  assign pwm_active = ({1'b0, cnt_reg} < pwm_duty);

  // PWM level before the invert bit
  always_comb
  begin
    unique case (action)
      `CTMM_PWM_INACTIVE:
      begin
        pwm_level = ~CFG.output_initial_level;
      end
      `CTMM_PWM_ACTIVE:
      begin
        pwm_level = CFG.output_initial_level;
      end
      `CTMM_PWM_WAVE:
      begin
        // Initial-level bit chooses active high or active low
        pwm_level = pwm_active ~^ CFG.output_initial_level;
      end
      default:
      begin
        // Undefined code: treat as forced inactive, safest for a load
        pwm_level = ~CFG.output_initial_level;
      end
    endcase
  end

  // Final pin level; the invert bit acts after the mode logic
  always_comb
  begin
    if (mode_pwm)
    begin
      out_next = pwm_level ^ CFG.output_invert;
    end
    else if (mode_cmp)
    begin
      out_next = cmp_pin_next ^ CFG.output_invert;
    end
    else
    begin
      // Timer/counter mode leaves the pin to other functions
      out_next = 1'b0;
    end
  end

  // Output registers; the PWM level trails the counter by one clock
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      out_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end
    else if (CE)
    begin
      out_reg <= out_next;
      out_en_reg <= mode_cmp | mode_pwm;
    end
  end

  assign MATCH_A_FLAG = flag_val[0];
  assign MATCH_P_FLAG = flag_val[1];
  assign COUNT = cnt_reg;
  assign TIMER_OUT = out_reg;
  assign TIMER_OUT_EN = out_en_reg;

endmodule
`default_nettype wire

// ---- sim/ctmm_timer_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctmm_timer_monitor
  import ctmm_pkg::*;
#(
  parameter logic WIDE = 1'b0
)
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire ctmm_cfg_s CFG,
  input wire logic COUNTER_ON,
  input wire ctmm_cnt_t COMPARE_A_VALUE,
  input wire logic [7:0] PERIOD_COMPARE_VALUE,
  input wire logic MATCH_A_FLAG_CLR,
  input wire logic MATCH_P_FLAG_CLR,
  input wire logic MATCH_A_FLAG,
  input wire logic MATCH_P_FLAG,
  input wire ctmm_cnt_t COUNT,
  input wire logic TIMER_OUT,
  input wire logic TIMER_OUT_EN
);
  // Copy of the run state, follows counter-on at enabled edges
  logic run_reg;
  // Decoded mode, action and expectations
  logic run, cmpm, ini, hit, ex_cmp, ex_pwm;
  logic [1:0] md, io;
  ctmm_span_t inc, av, ps, full, per, dty;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // Run state tracker
  always_ff @(posedge REF_CLK)
    if (!RST_N)
      run_reg <= 1'b0;
    else if (CE)
      run_reg <= COUNTER_ON;
  // Targets are 17 bits wide so a full-scale period is representable
  always_comb
  begin
    md = {CFG.mode_select_high, CFG.mode_select_low};
    io = {CFG.output_action_high, CFG.output_action_low};
    cmpm = (md == 2'h0) || (md == 2'h3);
    run = CE && run_reg && COUNTER_ON;
    ini = CFG.output_initial_level ^ CFG.output_invert;
    inc = {1'b0, COUNT} + 17'h00001;
    full = WIDE ? 17'h10000 : 17'h00400;
    av = WIDE ? {1'b0, COMPARE_A_VALUE} : {7'h00, COMPARE_A_VALUE[9:0]};
    if (WIDE)
      ps = (PERIOD_COMPARE_VALUE == 8'h00) ? full : {1'b0, PERIOD_COMPARE_VALUE, 8'h00};
    else
      ps = (PERIOD_COMPARE_VALUE[2:0] == 3'h0) ? full : {7'h00, PERIOD_COMPARE_VALUE[2:0], 7'h00};
    per = CFG.period_duty_swap ? ((av == 17'h00000) ? full : av) : ps;
    dty = CFG.period_duty_swap ? ps : av;
    hit = (av != 17'h00000) && (inc == av);
    ex_cmp = (io == 2'h0) ? TIMER_OUT : (io == 2'h3) ? !TIMER_OUT : (io[1] ^ CFG.output_invert);
    ex_pwm = ((io == 2'h1) || ((io == 2'h2) && (({1'b0, COUNT} < dty) || (dty >= per)))) ? ini : !ini;
  end
  on_zero_a: assert property ((CE && !run_reg && COUNTER_ON) |=> COUNT == 16'h0000)
    else $error("count not zeroed");
  p_clear_a: assert property ((run && cmpm && !CFG.clear_on_a_select && inc == ps) |=> (COUNT == 16'h0000) && MATCH_P_FLAG)
    else $error("no clear on p match");
  no_p_flag_a: assert property ((CE && cmpm && CFG.clear_on_a_select && !MATCH_P_FLAG) |=> !MATCH_P_FLAG)
    else $error("p flag with clear on a");
  ovf_quiet_a: assert property ((run && cmpm && CFG.clear_on_a_select && av == 17'h00000 && inc == full
    && !MATCH_A_FLAG) |=> (COUNT == 16'h0000) && !MATCH_A_FLAG)
    else $error("bad overflow");
  a_flag_a: assert property ((run && md != 2'h1 && hit) |=> MATCH_A_FLAG)
    else $error("a flag missing");
  cmp_pin_a: assert property ((run && md == 2'h0 && hit) |=> TIMER_OUT == $past(ex_cmp))
    else $error("pin action wrong");
  cmp_hold_a: assert property ((run && md == 2'h0 && !hit) |=> $stable(TIMER_OUT))
    else $error("pin moved without a match");
  tmr_free_a: assert property ((CE && md == 2'h3) |=> !TIMER_OUT_EN)
    else $error("pin driven in timer mode");
  pwm_clear_a: assert property ((run && md == 2'h2 && inc == per) |=> COUNT == 16'h0000)
    else $error("pwm period wrong");
  pwm_pin_a: assert property ((run && md == 2'h2) |=> TIMER_OUT == $past(ex_pwm))
    else $error("pwm level wrong");
  cover property (run && md == 2'h2 && inc == per);
  cover property (run && md == 2'h0 && hit);
  cover property (run && CFG.clear_on_a_select && av == 17'h00000 && inc == full);
endmodule
bind ctmm_timer ctmm_timer_monitor #(.WIDE(WIDE)) i_mon (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .CFG(CFG),
  .COUNTER_ON(COUNTER_ON), .COMPARE_A_VALUE(COMPARE_A_VALUE), .PERIOD_COMPARE_VALUE(PERIOD_COMPARE_VALUE),
  .MATCH_A_FLAG_CLR(MATCH_A_FLAG_CLR), .MATCH_P_FLAG_CLR(MATCH_P_FLAG_CLR), .MATCH_A_FLAG(MATCH_A_FLAG),
  .MATCH_P_FLAG(MATCH_P_FLAG), .COUNT(COUNT), .TIMER_OUT(TIMER_OUT), .TIMER_OUT_EN(TIMER_OUT_EN));
`default_nettype wire

// ---- sim/tb_ctmm_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin $display("[FAIL] %s expected %0h seen %0h", nm, e, g); errors++; end end
module tb_ctmm_timer import ctmm_pkg::*;;
  // Stimulus, held by non-blocking writes at rising edges
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  logic COUNTER_ON = 1'b0;
  logic MATCH_A_FLAG_CLR = 1'b0;
  logic MATCH_P_FLAG_CLR = 1'b0;
  ctmm_cfg_s CFG = 8'h00;
  ctmm_cnt_t COMPARE_A_VALUE = 16'h0000;
  logic [7:0] PERIOD_COMPARE_VALUE = 8'h00;
  logic MATCH_A_FLAG, MATCH_P_FLAG, TIMER_OUT, TIMER_OUT_EN;
  logic W_MATCH_P_FLAG, W_TIMER_OUT, W_TIMER_OUT_EN;
  ctmm_cnt_t COUNT;
  int errors = 0;
  int n_compared = 0;
  // 25 MHz clock
  always #20 REF_CLK = ~REF_CLK;
  ctmm_timer #(.WIDE(1'b0)) i_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .CFG(CFG), .COUNTER_ON(COUNTER_ON),
    .COMPARE_A_VALUE(COMPARE_A_VALUE), .PERIOD_COMPARE_VALUE(PERIOD_COMPARE_VALUE),
    .MATCH_A_FLAG_CLR(MATCH_A_FLAG_CLR), .MATCH_P_FLAG_CLR(MATCH_P_FLAG_CLR), .MATCH_A_FLAG(MATCH_A_FLAG),
    .MATCH_P_FLAG(MATCH_P_FLAG), .COUNT(COUNT), .TIMER_OUT(TIMER_OUT), .TIMER_OUT_EN(TIMER_OUT_EN));
  // Sixteen-bit instance on the same stimulus, so the wide period scaling is exercised too
  ctmm_timer #(.WIDE(1'b1)) i_dut_wide (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE), .CFG(CFG),
    .COUNTER_ON(COUNTER_ON), .COMPARE_A_VALUE(COMPARE_A_VALUE), .PERIOD_COMPARE_VALUE(PERIOD_COMPARE_VALUE),
    .MATCH_A_FLAG_CLR(MATCH_A_FLAG_CLR), .MATCH_P_FLAG_CLR(MATCH_P_FLAG_CLR), .MATCH_A_FLAG(),
    .MATCH_P_FLAG(W_MATCH_P_FLAG), .COUNT(), .TIMER_OUT(W_TIMER_OUT), .TIMER_OUT_EN(W_TIMER_OUT_EN));
  // Verdict and end of run
  task conclude;
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  // Stop, reconfigure and clear flags, then start; config only changes while off
  task automatic arm(input logic [1:0] m, input logic [1:0] o, input logic ini, input logic inv,
    input logic sw, input logic cc, input ctmm_cnt_t a, input logic [7:0] p);
    @(posedge REF_CLK);
    COUNTER_ON <= 1'b0;
    CFG <= ctmm_cfg_s'({m, o, ini, inv, sw, cc});
    COMPARE_A_VALUE <= a;
    PERIOD_COMPARE_VALUE <= p;
    MATCH_A_FLAG_CLR <= 1'b1;
    MATCH_P_FLAG_CLR <= 1'b1;
    @(posedge REF_CLK);
    MATCH_A_FLAG_CLR <= 1'b0;
    MATCH_P_FLAG_CLR <= 1'b0;
    COUNTER_ON <= 1'b1;
    #1;
  endtask
  // Wait a fixed count of edges, then sample once settled
  task automatic tk(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  // Count edges until a flag rises; bounded so a dead flag cannot hang
  task automatic wt(input logic sel, input int e);
    int n;
    n = 0;
    while (((sel ? MATCH_P_FLAG : MATCH_A_FLAG) !== 1'b1) && n < 3000)
    begin
      @(posedge REF_CLK);
      #1;
      n++;
    end
    `CHK("edges to flag", e, n)
  endtask
  // One PWM setup: active cycles over one full period window (clear-on-A set on purpose)
  task automatic pw(input logic sw, input logic [1:0] o, input logic ini, input logic inv,
    input ctmm_cnt_t a, input int per, input int eh);
    int h;
    arm(2'h2, o, ini, inv, sw, 1'b1, a, 8'h01);
    tk(per + 4);
    h = 0;
    repeat (per)
    begin
      @(posedge REF_CLK);
      #1;
      h += (TIMER_OUT === 1'b1);
    end
    `CHK("pwm active cycles", eh, h)
    `CHK("pwm p flag", 1'b1, MATCH_P_FLAG)
    done("pwm");
  endtask
  // Both widths side by side; the 768-clock window is a whole number of periods for each
  task automatic pw_pair(input logic sw, input ctmm_cnt_t a, input int eh, input int ehw);
    int h;
    int hw;
    arm(2'h2, 2'h2, 1'b1, 1'b0, sw, 1'b0, a, 8'h01);
    tk(8);
    h = 0;
    hw = 0;
    repeat (768)
    begin
      @(posedge REF_CLK);
      #1;
      h += (TIMER_OUT === 1'b1);
      hw += (W_TIMER_OUT === 1'b1);
    end
    `CHK("pwm active cycles", eh, h)
    `CHK("wide pwm active cycles", ehw, hw)
    `CHK("wide p flag", 1'b1, W_MATCH_P_FLAG)
    `CHK("wide pin enable", 1'b1, W_TIMER_OUT_EN)
    done("pwm pair");
  endtask
  // Watchdog, well beyond the roughly 6000 cycles the tests need
  initial
  begin
    repeat (40000) @(posedge REF_CLK);
    errors++;
    conclude();
  end
  initial
  begin
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    // Every compare action: P period 128, A at 50
    for (int i = 0; i < 4; i++)
    begin
      arm(2'h0, 2'(i), i < 2, i == 3, 1'b0, 1'b0, 16'h0032, 8'h01);
      wt(1'b0, 51);
      `CHK("count at a match", 16'h0032, COUNT)
      `CHK("pin after a match", !i[0], TIMER_OUT)
      `CHK("pin enable", 1'b1, TIMER_OUT_EN)
      wt(1'b1, 78);
      `CHK("count after p clear", 16'h0000, COUNT)
      `CHK("pin after p match", !i[0], TIMER_OUT)
      done("compare");
    end
    // Clear on A at 300 while the P span is only 128
    arm(2'h0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h012C, 8'h01);
    wt(1'b0, 301);
    `CHK("count after a clear", 16'h0000, COUNT)
    tk(400);
    `CHK("p flag quiet", 1'b0, MATCH_P_FLAG)
    `CHK("pin at initial level", 1'b1, TIMER_OUT)
    done("clear on a");
    // Clear on A with a zero A value: full-scale overflow, no flag
    arm(2'h0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 8'h01);
    tk(1024);
    `CHK("count at full scale", 16'h03FF, COUNT)
    tk(1);
    `CHK("count after overflow", 16'h0000, COUNT)
    `CHK("a flag quiet", 1'b0, MATCH_A_FLAG)
    `CHK("pin untouched", 1'b0, TIMER_OUT)
    done("overflow");
    // Timer mode: same flags, pin released
    arm(2'h3, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0032, 8'h01);
    wt(1'b1, 129);
    `CHK("timer a flag", 1'b1, MATCH_A_FLAG)
    `CHK("timer pin enable", 1'b0, TIMER_OUT_EN)
    // Clock enable low freezes the count; the edge that lowers it still counts
    @(posedge REF_CLK);
    CE <= 1'b0;
    tk(5);
    `CHK("count frozen", 16'h0001, COUNT)
    @(posedge REF_CLK);
    CE <= 1'b1;
    done("timer");
    // Undefined mode code: the start zeroes the count, which then holds, pin released
    arm(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0032, 8'h01);
    tk(10);
    `CHK("count held in mode 01", 16'h0000, COUNT)
    `CHK("pin enable in mode 01", 1'b0, TIMER_OUT_EN)
    done("undefined mode");
    // PWM: swap, full duty, forced levels, invert and active low
    pw(1'b0, 2'h2, 1'b1, 1'b0, 16'h0020, 128, 32);
    pw(1'b1, 2'h2, 1'b1, 1'b0, 16'h00C8, 200, 128);
    pw(1'b0, 2'h2, 1'b1, 1'b0, 16'h00C8, 128, 128);
    pw(1'b0, 2'h0, 1'b1, 1'b0, 16'h0020, 128, 0);
    pw(1'b0, 2'h1, 1'b1, 1'b0, 16'h0020, 128, 128);
    pw(1'b0, 2'h2, 1'b1, 1'b1, 16'h0020, 128, 96);
    pw(1'b0, 2'h2, 1'b0, 1'b0, 16'h0020, 128, 96);
    // Ten-bit period 128 duty 64, sixteen-bit period 256 duty 64
    pw_pair(1'b0, 16'h0040, 384, 192);
    // Swapped: both periods 768, duties 128 and 256 from the coarse value
    pw_pair(1'b1, 16'h0300, 128, 256);
    conclude();
  end
endmodule
`default_nettype wire
